/* File: core/pll_pump_autocal_pd_config_regs.sv */
// Charge pump, VCO calibration and phase detector control registers
//
// Notes on behaviour
// - Down pump gain, bits 6:0, 20 uA per step, resets to 100.
// - Up pump gain, bits 13:7, same 20 uA scale, resets to 100.
// - Leak magnitude, bits 20:14, 5 uA per step, resets to zero.
// - Leak magnitude with direction enables sets injected leak amount and polarity.
// - Resolution bits 2:0 select 1..256 reference cycles; resets to 5.
// - Bit 10 forces stored curve, bit 11 bypasses tuning; both reset zero.
// - Write to address 05h triggers VCO port transfer unless bit 12 set.
// - Bits 14:13 select crystal divide 1,4,16,32; resets to code 1, divide 4; max 50 MHz.
// - Bits 5 and 6 enable detector up and down outputs; reset one.
// - Slip guard bits 8:7: off, or 5.4, 14.4, 24.1 ns thresholds.
// - Bits 9 and 10 force pump up and down on; test only; reset zero.
module pll_pump_autocal_pd_config_regs (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        sck,
   input  wire logic        sdi,
   input  wire logic        sen_b,
   output logic             sdo,
   output logic             sdo_oe,
   output logic [6:0]       pump_down_gain,
   output logic [6:0]       pump_up_gain,
   output logic [6:0]       leak_source_code,
   output logic [6:0]       leak_sink_code,
   output logic [8:0]       tune_measure_cycles,
   output logic             force_curve,
   output logic             bypass_vco_tuning,
   output logic             vco_port_trigger,
   output logic [5:0]       fsm_clock_divide,
   output logic [2:0]       detector_reset_delay_select,
   output logic             detector_up_enable,
   output logic             detector_down_enable,
   output logic [1:0]       cycle_slip_guard_mode,
   output logic             pump_up_force,
   output logic             pump_down_force
);

   typedef struct packed {
      logic [23:0] pump;
      logic [23:0] cal;
      logic [23:0] det;
      logic        trig;
      logic [6:0]  src;
      logic [6:0]  snk;
      logic [8:0]  cyc;
      logic [5:0]  div;
   } bank_s;

   bank_s q;
   bank_s d;

   logic        wr_pulse;
   logic [5:0]  wr_addr;
   logic [23:0] wr_data;
   logic [5:0]  rd_addr;
   logic [23:0] rd_data;

   // ==========================================================
   // Serial port
   serial_frame_port serial_frame_port_i (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .sck      (sck),
      .sdi      (sdi),
      .sen_b    (sen_b),
      .rd_data  (rd_data),
      .wr_pulse (wr_pulse),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data),
      .rd_addr  (rd_addr),
      .sdo      (sdo),
      .sdo_oe   (sdo_oe)
   );

   // Read-back mux; unmapped addresses read zero
   always_comb begin
      case (rd_addr)
         pll_cfg_pkg::ADDR_PUMP_CTRL:     rd_data = q.pump;
         pll_cfg_pkg::ADDR_VCO_CAL:       rd_data = q.cal;
         pll_cfg_pkg::ADDR_DETECTOR_CTRL: rd_data = q.det;
         default:                         rd_data = 24'h000000;
      endcase
   end

   // ==========================================================
   // Register bank and derived controls
   always_comb begin
      logic [23:0] np;
      logic [23:0] nc;
      logic [6:0]  mag;
      np     = q.pump;
      nc     = q.cal;
      mag    = 7'h00;
      d      = q;
      d.trig = 1'b0;
      if (wr_pulse) begin
         case (wr_addr)
            pll_cfg_pkg::ADDR_PUMP_CTRL:     d.pump = wr_data;
            pll_cfg_pkg::ADDR_VCO_CAL:       d.cal  = wr_data;
            pll_cfg_pkg::ADDR_DETECTOR_CTRL: d.det  = wr_data;
            default:                         d.pump = q.pump;
         endcase
         // Tune word write starts a VCO port transfer unless suppressed
         d.trig = (wr_addr == pll_cfg_pkg::ADDR_VCO_TUNE) &&
                  !q.cal[pll_cfg_pkg::NO_TRIGGER_BIT];
      end
      np  = d.pump;
      nc  = d.cal;
      mag = np[pll_cfg_pkg::LEAK_MAG_LSB +: 7];
      // Leak polarity routes the magnitude to source or sink
      d.src = np[pll_cfg_pkg::LEAK_POS_BIT] ? mag : 7'h00;
      d.snk = np[pll_cfg_pkg::LEAK_NEG_BIT] ? mag : 7'h00;
      d.cyc = pll_cfg_pkg::resolution_cycles(
                 nc[pll_cfg_pkg::RESOLUTION_LSB +: 3]);
      d.div = pll_cfg_pkg::fsm_clock_ratio(
                 nc[pll_cfg_pkg::FSM_CLK_SEL_LSB +: 2]);
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q.pump <= pll_cfg_pkg::RST_PUMP_CTRL;
         q.cal  <= pll_cfg_pkg::RST_VCO_CAL;
         q.det  <= pll_cfg_pkg::RST_DETECTOR_CTRL;
         q.trig <= 1'b0;
         q.src  <= 7'h00;
         q.snk  <= 7'h00;
         q.cyc  <= 9'h040;
         q.div  <= 6'h04;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Field outputs, each straight from the bank flops
   assign pump_down_gain   = q.pump[pll_cfg_pkg::DN_GAIN_LSB +: 7];
   assign pump_up_gain     = q.pump[pll_cfg_pkg::UP_GAIN_LSB +: 7];
   assign leak_source_code = q.src;
   assign leak_sink_code   = q.snk;
   assign tune_measure_cycles = q.cyc;
   assign force_curve       = q.cal[pll_cfg_pkg::FORCE_CURVE_BIT];
   assign bypass_vco_tuning = q.cal[pll_cfg_pkg::BYPASS_TUNE_BIT];
   assign vco_port_trigger  = q.trig;
   assign fsm_clock_divide  = q.div;
   assign detector_reset_delay_select =
      q.det[pll_cfg_pkg::DELAY_SEL_LSB +: 3];
   assign detector_up_enable   = q.det[pll_cfg_pkg::DET_UP_EN_BIT];
   assign detector_down_enable = q.det[pll_cfg_pkg::DET_DN_EN_BIT];
   assign cycle_slip_guard_mode =
      q.det[pll_cfg_pkg::SLIP_MODE_LSB +: 2];
   assign pump_up_force   = q.det[pll_cfg_pkg::UP_FORCE_BIT];
   assign pump_down_force = q.det[pll_cfg_pkg::DN_FORCE_BIT];

   // ==========================================================
   // Checks
   a_down_gain_write: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wr_pulse && wr_addr == pll_cfg_pkg::ADDR_PUMP_CTRL
      |=> pump_down_gain == $past(wr_data[6:0]))
      else $error("Down gain not loaded from write");

   a_up_gain_write: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wr_pulse && wr_addr == pll_cfg_pkg::ADDR_PUMP_CTRL
      |=> pump_up_gain == $past(wr_data[13:7]))
      else $error("Up gain not loaded from write");

   a_leak_route: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wr_pulse && wr_addr == pll_cfg_pkg::ADDR_PUMP_CTRL
      |=> leak_sink_code == ($past(wr_data[22]) ? $past(wr_data[20:14])
                                                : 7'h00)
          && leak_source_code == ($past(wr_data[21]) ?
                                  $past(wr_data[20:14]) : 7'h00))
      else $error("Leak code does not follow magnitude and direction");

   a_resolution_map: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wr_pulse && wr_addr == pll_cfg_pkg::ADDR_VCO_CAL
      |=> tune_measure_cycles ==
          pll_cfg_pkg::resolution_cycles($past(wr_data[2:0])))
      else $error("Measure cycles do not match resolution code");

   a_trigger_cause: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      vco_port_trigger |-> $past(wr_pulse) && $past(wr_addr) == 6'h05
                           && !$past(q.cal[12]))
      else $error("Transfer trigger without an allowed tune write");

   a_trigger_fires: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wr_pulse && wr_addr == 6'h05 && !q.cal[12]
      |=> vco_port_trigger ##1 !vco_port_trigger)
      else $error("Tune write did not give one trigger pulse");

   a_clock_divide: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $changed(fsm_clock_divide) |->
         $past(wr_pulse) && $past(wr_addr) == 6'h0a)
      else $error("Calibration divider changed without a write");

   a_detector_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !(wr_pulse && wr_addr == pll_cfg_pkg::ADDR_DETECTOR_CTRL)
      |=> $stable(detector_up_enable) && $stable(detector_down_enable)
          && $stable(cycle_slip_guard_mode) && $stable(pump_up_force)
          && $stable(pump_down_force))
      else $error("Detector controls changed without a write");

   a_force_write: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      wr_pulse && wr_addr == pll_cfg_pkg::ADDR_DETECTOR_CTRL
      |=> pump_up_force == $past(wr_data[9])
          && pump_down_force == $past(wr_data[10]))
      else $error("Force bits not loaded from write");

endmodule

/* File: core/pll_cfg_pkg.sv */
// Package: offsets, field positions, reset values and frame layout
package pll_cfg_pkg;

   // ==========================================================
   // Register offsets on the serial programming port
   localparam logic [5:0] ADDR_VCO_TUNE      = 6'h05;
   localparam logic [5:0] ADDR_PUMP_CTRL     = 6'h09;
   localparam logic [5:0] ADDR_VCO_CAL       = 6'h0a;
   localparam logic [5:0] ADDR_DETECTOR_CTRL = 6'h0b;

   // ==========================================================
   // Reset values
   localparam logic [23:0] RST_PUMP_CTRL     = 24'h403264;
   localparam logic [23:0] RST_VCO_CAL       = 24'h002205;
   localparam logic [23:0] RST_DETECTOR_CTRL = 24'h0f8061;

   // ==========================================================
   // Charge pump control fields
   localparam int DN_GAIN_LSB   = 0;
   localparam int UP_GAIN_LSB   = 7;
   localparam int LEAK_MAG_LSB  = 14;
   localparam int LEAK_POS_BIT  = 21;
   localparam int LEAK_NEG_BIT  = 22;

   // ==========================================================
   // VCO calibration fields
   localparam int RESOLUTION_LSB  = 0;
   localparam int FORCE_CURVE_BIT = 10;
   localparam int BYPASS_TUNE_BIT = 11;
   localparam int NO_TRIGGER_BIT  = 12;
   localparam int FSM_CLK_SEL_LSB = 13;

   // ==========================================================
   // Phase detector fields
   localparam int DELAY_SEL_LSB  = 0;
   localparam int DET_UP_EN_BIT  = 5;
   localparam int DET_DN_EN_BIT  = 6;
   localparam int SLIP_MODE_LSB  = 7;
   localparam int UP_FORCE_BIT   = 9;
   localparam int DN_FORCE_BIT   = 10;

   // ==========================================================
   // Serial frame: one read flag, six address bits, 24 data bits
   localparam logic [4:0] FRAME_BITS  = 5'd31;
   localparam logic [4:0] HEADER_BITS = 5'd7;

   // Measurement length in reference-divider cycles per code
   function automatic logic [8:0] resolution_cycles(input logic [2:0] c);
      case (c)
         3'h0:    return 9'h001;
         3'h1:    return 9'h002;
         3'h2:    return 9'h004;
         3'h3:    return 9'h008;
         3'h4:    return 9'h020;
         3'h5:    return 9'h040;
         3'h6:    return 9'h080;
         default: return 9'h100;
      endcase
   endfunction

   // Crystal reference divide ratio for the calibration clock
   function automatic logic [5:0] fsm_clock_ratio(input logic [1:0] c);
      case (c)
         2'h0:    return 6'h01;
         2'h1:    return 6'h04;
         2'h2:    return 6'h10;
         default: return 6'h20;
      endcase
   endfunction

endpackage

/* File: core/serial_frame_port.sv */
// Serial programming port: pin synchronisers, frame shifter, read-back
module serial_frame_port (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        sck,
   input  wire logic        sdi,
   input  wire logic        sen_b,
   input  wire logic [23:0] rd_data,
   output logic             wr_pulse,
   output logic [5:0]       wr_addr,
   output logic [23:0]      wr_data,
   output logic [5:0]       rd_addr,
   output logic             sdo,
   output logic             sdo_oe
);

   typedef struct packed {
      logic [2:0]  s1;
      logic [2:0]  s2;
      logic        sck_d;
      logic        sen_d;
      logic [4:0]  cnt;
      logic [30:0] sh;
      logic        load;
      logic [23:0] tx;
      logic        sdo;
      logic        oe;
      logic        wr;
      logic [5:0]  addr;
      logic [23:0] data;
      logic [5:0]  raddr;
   } rx_s;

   rx_s q;
   rx_s d;

   // ==========================================================
   // Next state
   always_comb begin
      logic pin_sck;
      logic pin_sdi;
      logic pin_sen_b;
      logic rise;
      logic fall;
      logic [30:0] nsh;
      pin_sck   = q.s2[2];
      pin_sdi   = q.s2[1];
      pin_sen_b = q.s2[0];
      rise      = pin_sck & ~q.sck_d;
      fall      = ~pin_sck & q.sck_d;
      nsh       = {q.sh[29:0], pin_sdi};
      d         = q;
      d.s1      = {sck, sdi, sen_b};
      d.s2      = q.s1;
      d.sck_d   = pin_sck;
      d.sen_d   = pin_sen_b;
      d.wr      = 1'b0;
      d.load    = 1'b0;
      if (pin_sen_b) begin
         d.cnt = 5'd0;
         d.oe  = 1'b0;
         d.sdo = 1'b0;
         // Frame end: commit a complete write frame only
         if (!q.sen_d && q.cnt == pll_cfg_pkg::FRAME_BITS && !q.sh[30]) begin
            d.wr   = 1'b1;
            d.addr = q.sh[29:24];
            d.data = q.sh[23:0];
         end
      end else begin
         if (rise && q.cnt != pll_cfg_pkg::FRAME_BITS) begin
            d.sh  = nsh;
            d.cnt = q.cnt + 5'd1;
            // Header complete: a read fetches the addressed word
            if (q.cnt + 5'd1 == pll_cfg_pkg::HEADER_BITS && nsh[6]) begin
               d.raddr = nsh[5:0];
               d.load  = 1'b1;
            end
         end
         if (q.load) begin
            d.tx = rd_data;
            d.oe = 1'b1;
         end else if (fall && q.oe) begin
            d.sdo = q.tx[23];
            d.tx  = {q.tx[22:0], 1'b0};
         end
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign wr_pulse = q.wr;
   assign wr_addr  = q.addr;
   assign wr_data  = q.data;
   assign rd_addr  = q.raddr;
   assign sdo      = q.sdo;
   assign sdo_oe   = q.oe;

endmodule

/* File: tb/tb_pll_pump_autocal_pd_config_regs.sv */
// Testbench: serial writes, read-back and field outputs of the config bank
module tb_pll_pump_autocal_pd_config_regs;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Stimulus, observed outputs and bookkeeping
   logic        clk_sys;
   logic        rst_b;
   logic        sck;
   logic        sdi;
   logic        sen_b;
   logic        sdo;
   logic        sdo_oe;
   logic [6:0]  pump_down_gain;
   logic [6:0]  pump_up_gain;
   logic [6:0]  leak_source_code;
   logic [6:0]  leak_sink_code;
   logic [8:0]  tune_measure_cycles;
   logic        force_curve;
   logic        bypass_vco_tuning;
   logic        vco_port_trigger;
   logic [5:0]  fsm_clock_divide;
   logic [2:0]  detector_reset_delay_select;
   logic        detector_up_enable;
   logic        detector_down_enable;
   logic [1:0]  cycle_slip_guard_mode;
   logic        pump_up_force;
   logic        pump_down_force;
   logic [23:0] sp;
   logic [23:0] sc;
   logic [23:0] sd;
   logic [23:0] rd;
   int          mismatches = 0;
   int          check_count = 0;
   int          trig_cnt = 0;

   pll_pump_autocal_pd_config_regs pll_pump_autocal_pd_config_regs_i (
      .clk_sys(clk_sys), .rst_b(rst_b), .sck(sck), .sdi(sdi),
      .sen_b(sen_b), .sdo(sdo), .sdo_oe(sdo_oe),
      .pump_down_gain(pump_down_gain), .pump_up_gain(pump_up_gain),
      .leak_source_code(leak_source_code),
      .leak_sink_code(leak_sink_code),
      .tune_measure_cycles(tune_measure_cycles),
      .force_curve(force_curve), .bypass_vco_tuning(bypass_vco_tuning),
      .vco_port_trigger(vco_port_trigger),
      .fsm_clock_divide(fsm_clock_divide),
      .detector_reset_delay_select(detector_reset_delay_select),
      .detector_up_enable(detector_up_enable),
      .detector_down_enable(detector_down_enable),
      .cycle_slip_guard_mode(cycle_slip_guard_mode),
      .pump_up_force(pump_up_force), .pump_down_force(pump_down_force));

   // ==========================================================
   // Clock, trigger pulse counter and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) if (vco_port_trigger === 1'b1) trig_cnt++;

   initial begin
      repeat (100000) @(posedge clk_sys);
      mismatches++;
      finish_test();
   end

   // ==========================================================
   // Shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
      end
   endtask

   // One frame, sck phases of 4 clocks; sdo sampled late in each high phase
   task automatic frame(input logic rw, input logic [5:0] a,
                        input logic [23:0] d, input int nb,
                        output logic [23:0] q);
      logic [30:0] w;
      w = {rw, a, d};
      q = 24'h0;
      sen_b = 1'b0;
      for (int i = 0; i < nb; i++) begin
         sck = 1'b0;
         sdi = (i < 31) ? w[30-i] : ~sdi;
         tick(4);
         sck = 1'b1;
         tick(4);
         // A read bit only counts while the pin is driven
         if (i >= 7 && i < 31) q[30-i] = sdo & sdo_oe;
      end
      sck = 1'b0;
      tick(4);
      sen_b = 1'b1;
      sdi = ~sdi; // Released line shows no stale level
      tick(8);
   endtask

   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      frame(1'b0, a, d, 31, rd);
      if (a == pll_cfg_pkg::ADDR_PUMP_CTRL) sp = d;
      if (a == pll_cfg_pkg::ADDR_VCO_CAL) sc = d;
      if (a == pll_cfg_pkg::ADDR_DETECTOR_CTRL) sd = d;
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
      frame(1'b1, a, 24'h0, 31, rd);
      check(rd, exp);
      check(24'(sdo_oe), 24'h0); // Driver released after the frame
   endtask

   // Every field output except vco_port_trigger against the shadow copies of the three words
   task automatic fields();
      logic [8:0]  cyc [8] = '{9'h001, 9'h002, 9'h004, 9'h008,
                              9'h020, 9'h040, 9'h080, 9'h100};
      logic [5:0]  dv [4] = '{6'h01, 6'h04, 6'h10, 6'h20};
      logic [23:0] mag;
      mag = 24'(sp[20:14]);
      check(24'(pump_down_gain), 24'(sp[6:0]));
      check(24'(pump_up_gain), 24'(sp[13:7]));
      check(24'(leak_source_code), sp[21] ? mag : 24'h0);
      check(24'(leak_sink_code), sp[22] ? mag : 24'h0);
      check(24'(tune_measure_cycles), 24'(cyc[sc[2:0]]));
      check(24'({bypass_vco_tuning, force_curve}), 24'(sc[11:10]));
      check(24'(fsm_clock_divide), 24'(dv[sc[14:13]]));
      check(24'(detector_reset_delay_select), 24'(sd[2:0]));
      check(24'({detector_down_enable, detector_up_enable}),
            24'(sd[6:5]));
      check(24'(cycle_slip_guard_mode), 24'(sd[8:7]));
      check(24'({pump_down_force, pump_up_force}), 24'(sd[10:9]));
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_reset();
      fields();
      rd_chk(pll_cfg_pkg::ADDR_PUMP_CTRL, 24'h403264);
      rd_chk(pll_cfg_pkg::ADDR_VCO_CAL, 24'h002205);
      rd_chk(pll_cfg_pkg::ADDR_DETECTOR_CTRL, 24'h0f8061);
      check(24'(trig_cnt), 24'h0);
      $display("test reset done");
   endtask

   // Gain extremes and both leak directions
   task automatic test_pump();
      wr(pll_cfg_pkg::ADDR_PUMP_CTRL, 24'h3fff80);
      fields();
      rd_chk(pll_cfg_pkg::ADDR_PUMP_CTRL, 24'h3fff80);
      wr(pll_cfg_pkg::ADDR_PUMP_CTRL, 24'h40407f);
      fields();
      rd_chk(pll_cfg_pkg::ADDR_PUMP_CTRL, 24'h40407f);
      $display("test pump done");
   endtask

   // Every resolution and divider code, with the curve and bypass bits
   task automatic test_cal();
      logic [2:0]  c;
      logic [23:0] d;
      for (int k = 0; k < 8; k++) begin
         c = 3'(k);
         d = {9'h0, c[1:0], 1'b1, c[1], c[0], 7'h40, c};
         wr(pll_cfg_pkg::ADDR_VCO_CAL, d);
         fields();
         rd_chk(pll_cfg_pkg::ADDR_VCO_CAL, d);
      end
      $display("test cal done");
   endtask

   // Writes to the tuning word pulse once, and not when suppressed
   task automatic test_trigger();
      wr(pll_cfg_pkg::ADDR_VCO_CAL, 24'h002205);
      trig_cnt = 0;
      wr(pll_cfg_pkg::ADDR_VCO_TUNE, 24'h000123);
      check(24'(trig_cnt), 24'h1);
      wr(pll_cfg_pkg::ADDR_VCO_CAL, 24'h003205);
      trig_cnt = 0;
      wr(pll_cfg_pkg::ADDR_VCO_TUNE, 24'h000123);
      check(24'(trig_cnt), 24'h0);
      fields();
      $display("test trigger done");
   endtask

   // Slip modes, output enables and forcing bits
   task automatic test_det();
      logic [1:0]  m;
      logic [23:0] d;
      for (int k = 0; k < 4; k++) begin
         m = 2'(k);
         d = {pll_cfg_pkg::RST_DETECTOR_CTRL[23:11], m[1], m[0], m, ~m,
              2'h0, 3'h1};
         wr(pll_cfg_pkg::ADDR_DETECTOR_CTRL, d);
         fields();
         rd_chk(pll_cfg_pkg::ADDR_DETECTOR_CTRL, d);
      end
      $display("test detector done");
   endtask

   // Short frame, long frame, unmapped write and read
   task automatic test_refuse();
      frame(1'b0, pll_cfg_pkg::ADDR_PUMP_CTRL, 24'h000000, 30, rd);
      fields();
      frame(1'b0, pll_cfg_pkg::ADDR_PUMP_CTRL, 24'h403264, 33, rd);
      sp = 24'h403264;
      fields();
      trig_cnt = 0;
      wr(6'h20, 24'hffffff);
      check(24'(trig_cnt), 24'h0);
      fields();
      rd_chk(6'h3f, 24'h000000);
      $display("test refuse done");
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      sck = 1'b0;
      sdi = 1'b0;
      sen_b = 1'b1;
      sp = pll_cfg_pkg::RST_PUMP_CTRL;
      sc = pll_cfg_pkg::RST_VCO_CAL;
      sd = pll_cfg_pkg::RST_DETECTOR_CTRL;
      tick(10);
      fields();
      rst_b = 1'b1;
      tick(3);
      test_reset();
      test_pump();
      test_cal();
      test_trigger();
      test_det();
      test_refuse();
      finish_test();
   end
endmodule
